/* File: inc/dpbsi_pkg.sv */
// Shared constants and pin bundle for the dual port burst memory interface
package dpbsi_pkg;
   localparam int unsigned DATA_W   = 18;
   localparam int unsigned ADDR_W   = 4;
   localparam int unsigned BEAT_W   = 3;
   localparam int unsigned IDX_W    = ADDR_W + 2;
   localparam int unsigned DEPTH    = 64;
   localparam logic [BEAT_W-1:0] BEATS_PER_BURST = 3'h4;
   localparam logic [BEAT_W-1:0] LAST_WR_BEAT    = 3'h3;
   localparam logic [1:0]        RD_LAT_FULL     = 2'h2;
   localparam logic [1:0]        RD_LAT_LEGACY   = 2'h1;
   localparam logic [DATA_W-1:0] RDATA_RST       = 18'h0_0000;

   typedef enum logic {SLOT_RD, SLOT_WR} dpbsi_slot_t;

   // Everything the controller drives, sampled together
   typedef struct packed {
      logic              k;
      logic              k_n;
      logic              rd_sel_n;
      logic              wr_sel_n;
      logic              loop_disable_pin;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } dpbsi_pins_t;

   // Idle pin levels: complement clock high, both selects inactive
   localparam dpbsi_pins_t PINS_RST = '{k: 1'b0, k_n: 1'b1, rd_sel_n: 1'b1, wr_sel_n: 1'b1,
                                        loop_disable_pin: 1'b1, addr: 4'h0, wdata: 18'h0_0000};
endpackage : dpbsi_pkg

/* File: logic/dpbsi_core.sv */
// Device side of the dual port burst memory interface
`timescale 1ns/10ps
`default_nettype none
module dpbsi_core
(
   input  wire logic                         clk,
   input  wire logic                         rst,
   input  wire dpbsi_pkg::dpbsi_pins_t       pins,
   output logic [dpbsi_pkg::DATA_W-1:0]      rd_data,
   output logic                              read_valid_flag,
   output logic                              echo_clock_out,
   output logic                              echo_clock_n_out
);
   import dpbsi_pkg::*;

   function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a, input logic [BEAT_W-1:0] b);
      word_idx = {a, b[1:0]};
   endfunction : word_idx

   dpbsi_pins_t         sync1_ff;
   dpbsi_pins_t         sync2_ff;
   logic                k_d_ff;
   logic                kn_d_ff;
   dpbsi_slot_t         slot_ff;
   logic                wait_vld_ff;
   logic [1:0]          wait_cnt_ff;
   logic [ADDR_W-1:0]   wait_addr_ff;
   logic                burst_vld_ff;
   logic [BEAT_W-1:0]   beat_ff;
   logic [ADDR_W-1:0]   burst_addr_ff;
   logic                wr_act_ff;
   logic [BEAT_W-1:0]   wr_beat_ff;
   logic [ADDR_W-1:0]   wr_addr_ff;
   logic [DATA_W-1:0]   rd_data_ff;
   logic                valid_ff;
   logic                echo_ff;
   logic                echo_n_ff;
   logic [DATA_W-1:0]   mem [DEPTH];

   logic                k_rise;
   logic                kn_rise;
   logic                any_edge;
   logic                rd_take;
   logic                wr_take;
   logic                launch_start;
   logic                launch_mid;
   logic [IDX_W-1:0]    l_idx;
   logic [DATA_W-1:0]   l_word;
   logic                fwd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling; the first stage feeds only the second
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         // Idle levels, so no false clock edge or select follows reset
         sync1_ff <= PINS_RST;
         sync2_ff <= PINS_RST;
         k_d_ff   <= 1'b0;
         kn_d_ff  <= 1'b1;
      end
      else
      begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
         k_d_ff   <= sync2_ff.k;
         kn_d_ff  <= sync2_ff.k_n;
      end
   end

   // Rising edges only; falling edges are never decoded
   assign k_rise   = sync2_ff.k & ~k_d_ff;
   assign kn_rise  = sync2_ff.k_n & ~kn_d_ff;
   assign any_edge = k_rise | kn_rise;

   ////////////////////////////////////////////////////////////////////////////
   // Address slot alternates on each true clock rise
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         slot_ff <= SLOT_RD;
      else if (k_rise)
         slot_ff <= (slot_ff == SLOT_RD) ? SLOT_WR : SLOT_RD;
   end

   // Each port listens only in its own slot and with its own select
   assign rd_take = k_rise && (slot_ff == SLOT_RD) && !sync2_ff.rd_sel_n;
   assign wr_take = k_rise && (slot_ff == SLOT_WR) && !sync2_ff.wr_sel_n;

   ////////////////////////////////////////////////////////////////////////////
   // Read address waits out the latency chosen by the loop disable pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wait_vld_ff  <= 1'b0;
         wait_cnt_ff  <= 2'h0;
         wait_addr_ff <= '0;
      end
      else if (k_rise)
      begin
         if (rd_take)
         begin
            wait_vld_ff  <= 1'b1;
            wait_addr_ff <= sync2_ff.addr;
            wait_cnt_ff  <= sync2_ff.loop_disable_pin ? RD_LAT_FULL : RD_LAT_LEGACY;
         end
         else if (launch_start)
            wait_vld_ff <= 1'b0;
         else if (wait_vld_ff)
            wait_cnt_ff <= wait_cnt_ff - 2'h1;
      end
   end

   assign launch_start = k_rise && wait_vld_ff && (wait_cnt_ff == 2'h1);
   assign launch_mid   = burst_vld_ff && ((k_rise && beat_ff == 3'h2) ||
                         (kn_rise && (beat_ff == 3'h1 || beat_ff == 3'h3)));
   assign l_idx        = launch_start ? word_idx(wait_addr_ff, 3'h0) : word_idx(burst_addr_ff, beat_ff);
   // A word being written on this very edge is forwarded to the read
   assign fwd_hit      = wr_act_ff && any_edge && (word_idx(wr_addr_ff, wr_beat_ff) == l_idx);
   assign l_word       = fwd_hit ? sync2_ff.wdata : mem[l_idx];

   ////////////////////////////////////////////////////////////////////////////
   // Read burst sequencing and output registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         burst_vld_ff  <= 1'b0;
         beat_ff       <= 3'h0;
         burst_addr_ff <= '0;
         rd_data_ff    <= RDATA_RST;
         valid_ff      <= 1'b0;
      end
      else if (launch_start)
      begin
         burst_vld_ff  <= 1'b1;
         burst_addr_ff <= wait_addr_ff;
         beat_ff       <= 3'h1;
         rd_data_ff    <= l_word;
         valid_ff      <= 1'b1;
      end
      else if (launch_mid)
      begin
         beat_ff    <= beat_ff + 3'h1;
         rd_data_ff <= l_word;
      end
      else if (k_rise && beat_ff == BEATS_PER_BURST)
      begin
         // Hold the last word a full half cycle, then drop valid
         burst_vld_ff <= 1'b0;
         beat_ff      <= 3'h0;
         valid_ff     <= 1'b0;
      end
   end

   // Echo clocks follow the sampled input clocks
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         echo_ff   <= 1'b0;
         echo_n_ff <= 1'b0;
      end
      else
      begin
         echo_ff   <= sync2_ff.k;
         echo_n_ff <= sync2_ff.k_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write burst: four words on the edges after the write address
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_act_ff  <= 1'b0;
         wr_beat_ff <= 3'h0;
         wr_addr_ff <= '0;
      end
      else if (wr_take)
      begin
         wr_act_ff  <= 1'b1;
         wr_beat_ff <= 3'h0;
         wr_addr_ff <= sync2_ff.addr;
      end
      else if (wr_act_ff && any_edge)
      begin
         wr_beat_ff <= wr_beat_ff + 3'h1;
         if (wr_beat_ff == LAST_WR_BEAT)
            wr_act_ff <= 1'b0;
      end
   end

   // Array has no reset; contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (wr_act_ff && any_edge)
         mem[word_idx(wr_addr_ff, wr_beat_ff)] <= sync2_ff.wdata;
   end

   assign rd_data          = rd_data_ff;
   assign read_valid_flag  = valid_ff;
   assign echo_clock_out   = echo_ff;
   assign echo_clock_n_out = echo_n_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_rd_cap_full;
      rd_take && sync2_ff.loop_disable_pin;
   endsequence
   sequence s_rd_cap_legacy;
      rd_take && !sync2_ff.loop_disable_pin;
   endsequence

   property p_slot_alt;
      @(posedge clk) disable iff (rst) k_rise |=> slot_ff != $past(slot_ff);
   endproperty
   a_slot_alt: assert property (p_slot_alt) else $error("slot did not alternate");

   property p_lat_full;
      @(posedge clk) disable iff (rst) s_rd_cap_full |=> wait_vld_ff && wait_cnt_ff == 2'h2;
   endproperty
   a_lat_full: assert property (p_lat_full) else $error("full latency not loaded");

   property p_lat_legacy;
      @(posedge clk) disable iff (rst) s_rd_cap_legacy |=> wait_vld_ff && wait_cnt_ff == 2'h1;
   endproperty
   a_lat_legacy: assert property (p_lat_legacy) else $error("legacy latency not loaded");

   property p_valid_burst;
      @(posedge clk) disable iff (rst) $rose(read_valid_flag) |-> burst_vld_ff && beat_ff == 3'h1;
   endproperty
   a_valid_burst: assert property (p_valid_burst) else $error("valid rose outside burst start");

   property p_echo;
      @(posedge clk) disable iff (rst) k_rise |=> echo_clock_out;
   endproperty
   a_echo: assert property (p_echo) else $error("echo clock missed rise");

   property p_fall_quiet;
      @(posedge clk) disable iff (rst) !$past(any_edge) |-> $stable(rd_data) && $stable(read_valid_flag);
   endproperty
   a_fall_quiet: assert property (p_fall_quiet) else $error("read outputs moved without a rising edge");

   property p_wr_select;
      @(posedge clk) disable iff (rst) $rose(wr_act_ff) |-> $past(wr_take);
   endproperty
   a_wr_select: assert property (p_wr_select) else $error("write began without select");

   property p_forward;
      @(posedge clk) disable iff (rst) (fwd_hit && (launch_start || launch_mid)) |=> rd_data == $past(sync2_ff.wdata);
   endproperty
   a_forward: assert property (p_forward) else $error("in-flight write not forwarded");
endmodule : dpbsi_core
`default_nettype wire

/* File: verification/dpbsi_core_tb_top.sv */
// Self-checking testbench of the dual port burst memory interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end
module dpbsi_core_tb_top;
   import dpbsi_pkg::*;
   localparam logic [4*DATA_W-1:0] W_A = 72'h01_2345_6789_abcd_ef01;
   localparam logic [4*DATA_W-1:0] W_B = 72'h3f_0f0f_a5a5_c3c3_1e1e;
   logic              clk;
   logic              rst;
   logic              run;
   dpbsi_pins_t       pins;
   logic [DATA_W-1:0] rd_data;
   logic              read_valid_flag;
   logic              echo_clock_out;
   logic              echo_clock_n_out;
   int                mismatches;
   int                n_compared;
   dpbsi_core dpbsi_core_inst (.clk(clk), .rst(rst), .pins(pins), .rd_data(rd_data),
      .read_valid_flag(read_valid_flag), .echo_clock_out(echo_clock_out), .echo_clock_n_out(echo_clock_n_out));
   dpbsi_host_model dpbsi_host_model_inst (.clk(clk), .run(run), .pins(pins));
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic at(input int p, input logic [2:0] f);
      do @(dpbsi_host_model_inst.tick); while (!(dpbsi_host_model_inst.per == p && dpbsi_host_model_inst.ph == f));
   endtask : at
   // Samples sit mid-word, clear of the three-clock sampling delay on both sides
   task automatic check_read(input int e, input int lat, input logic [4*DATA_W-1:0] w);
      at(e + lat - 1, 3'h5);
      `CHK("valid before latency", 1'b0, read_valid_flag)
      for (int i = 0; i < 4; i++)
      begin
         at(e + lat + (i + 1) / 2, (i % 2) ? 3'h1 : 3'h5);
         `CHK("read word", w[i*DATA_W +: DATA_W], rd_data)
         `CHK("read valid", 1'b1, read_valid_flag)
         `CHK("echo clock", (i % 2) ? 1'b0 : 1'b1, echo_clock_out)
         `CHK("echo clock complement", (i % 2) ? 1'b1 : 1'b0, echo_clock_n_out)
      end
      at(e + lat + 2, 3'h5);
      `CHK("valid after burst", 1'b0, read_valid_flag)
   endtask : check_read
   ////////////////////////////////////////////////////////////////////////////
   task automatic sc_write_then_read;
      int e;
      dpbsi_host_model_inst.issue(1'b1, 1'b1, 4'h3, W_A, 1'b1, e);
      for (int lat = 2; lat >= 1; lat--)
      begin
         dpbsi_host_model_inst.issue(1'b0, 1'b1, 4'h3, W_A, lat == 2, e);
         check_read(e, lat, W_A);
      end
   endtask : sc_write_then_read
   task automatic sc_deselect;
      int e;
      dpbsi_host_model_inst.issue(1'b1, 1'b0, 4'h3, W_B, 1'b1, e);
      dpbsi_host_model_inst.issue(1'b0, 1'b0, 4'h3, W_B, 1'b1, e);
      at(e + 2, 3'h5);
      `CHK("valid on deselected read", 1'b0, read_valid_flag)
      dpbsi_host_model_inst.issue(1'b0, 1'b1, 4'h3, W_B, 1'b1, e);
      check_read(e, 2, W_A);
   endtask : sc_deselect
   // Read issued while the write burst is still arriving
   task automatic sc_overlap;
      int ew;
      int er;
      fork
         dpbsi_host_model_inst.issue(1'b1, 1'b1, 4'h5, W_B, 1'b1, ew);
         begin
            wait (dpbsi_host_model_inst.pins.wr_sel_n === 1'b0);
            dpbsi_host_model_inst.issue(1'b0, 1'b1, 4'h5, W_B, 1'b0, er);
            check_read(er, 1, W_B);
         end
      join
   endtask : sc_overlap
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      run = 1'b0;
      mismatches = 0;
      n_compared = 0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      run <= 1'b1;
      sc_write_then_read();
      sc_deselect();
      sc_overlap();
      complete_run();
   end
   // A few hundred clocks are expected; this is far beyond
   initial
   begin
      #1000000;
      mismatches++;
      complete_run();
   end
endmodule : dpbsi_core_tb_top
`default_nettype wire

/* File: verification/dpbsi_host_model.sv */
// Host controller model: input clock pair, selects, address and write data
`timescale 1ns/10ps
`default_nettype none
module dpbsi_host_model
(
   input  wire logic               clk,
   input  wire logic               run,
   output var  dpbsi_pkg::dpbsi_pins_t pins
);
   import dpbsi_pkg::*;
   logic [2:0] ph;
   int         per;
   event       tick;
   initial
   begin
      ph   = 3'h7;
      per  = -1;
      pins = '{k: 1'b0, k_n: 1'b1, rd_sel_n: 1'b1, wr_sel_n: 1'b1, loop_disable_pin: 1'b1, addr: '0, wdata: '0};
   end
   ////////////////////////////////////////////////////////////////////////////
   // Clock pair runs free once started; eight system clocks per period
   always @(negedge clk)
   begin
      if (run)
      begin
         ph = ph + 3'h1;
         if (ph == 3'h0)
            per = per + 1;
         pins.k   = (ph < 3'h4);
         pins.k_n = !pins.k;
         -> tick;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Even rises carry reads, odd rises writes; one address per port per two periods
   task automatic issue(input logic wr, input logic sel, input logic [ADDR_W-1:0] a,
                        input logic [4*DATA_W-1:0] w, input logic lat2, output int edge_n);
      do @(tick); while (!(ph == 3'h6 && ((per + 1) % 2 == int'(wr))));
      edge_n = per + 1;
      pins.addr = a;
      if (wr)
         pins.wr_sel_n = !sel;
      else
      begin
         pins.rd_sel_n = !sel;
         pins.loop_disable_pin = lat2;
      end
      for (int i = 0; i < 5; i++)
      begin
         repeat (4) @(tick);
         if (i == 0)
         begin
            // Released lines show the inverse so a stale value cannot pass
            pins.addr = ~a;
            if (wr)
               pins.wr_sel_n = 1'b1;
            else
               pins.rd_sel_n = 1'b1;
         end
         if (!wr)
            break;
         pins.wdata = (i < 4) ? w[i*DATA_W +: DATA_W] : ~pins.wdata;
      end
   endtask : issue
endmodule : dpbsi_host_model
`default_nettype wire
